// >>> logic/bsa_pkg.sv
// Constants, encodings and carrier types of the 8-bit add datapath.
// Assumes a single core clock and a register file answering reads one cycle later.
package bsa_pkg;

	// ==========================================================
	// Opcode layout
	localparam logic [3:0] OP_HI_ADD = 4'h0; // Upper nibble of plain add
	localparam logic [3:0] OP_HI_ADC = 4'h1; // Upper nibble of add with carry
	localparam logic [3:0] MODE_WW = 4'h2; // Working dst, working src
	localparam logic [3:0] MODE_WI = 4'h3; // Working dst, indirect working src
	localparam logic [3:0] MODE_RR = 4'h4; // Register dst, register src
	localparam logic [3:0] MODE_RI = 4'h5; // Register dst, indirect src
	localparam logic [3:0] MODE_RL = 4'h6; // Register dst, literal src
	localparam logic [3:0] MODE_IL = 4'h7; // Indirect dst, literal src

	// ==========================================================
	// Operand encoding
	localparam logic [3:0] WORK_NIBBLE = 4'he; // Upper nibble that picks working registers
	localparam logic [7:0] BYTE_ZERO = 8'h00; // Zero result and reset value

	// ==========================================================
	// Timing
	localparam int INSTR_CYCLES = 10; // Core cycles per instruction
	localparam logic [3:0] LAST_CYCLE = 4'(INSTR_CYCLES - 1); // Count at completion
	localparam logic [3:0] ONE_CYCLE = 4'h1; // Counter step

	// ==========================================================
	// Carrier types
	typedef struct packed {
		logic [7:0] operation_code_byte; // Opcode, first in machine order
		logic [7:0] first_operand; // Byte after the opcode
		logic [7:0] second_operand; // Third byte
	} bsa_instr_type;

	typedef struct packed {
		logic c; // Carry
		logic z; // Zero
		logic s; // Sign
		logic v; // Overflow
		logic d; // Decimal adjust
		logic h; // Half carry
	} bsa_flags_type;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_PTR = 3'h1,
		ST_PTRL = 3'h3,
		ST_SRC = 3'h2,
		ST_DST = 3'h6,
		ST_CALC = 3'h7,
		ST_WR = 3'h5,
		ST_HOLD = 3'h4
	} bsa_state_type;

endpackage : bsa_pkg

// >>> logic/bsa_byte_sum_alu.sv
// Add and add-with-carry execution unit: operand fetch, sum, flags and write-back.
// Assumes the decoder presents whole instructions on a start pulse and the register
// file answers a read strobe with data in the next cycle.
//
// Behaviour
// - Upper nibble E selects sixteen working registers
// - Upper nibble E selects a working register pair
// - Opcode first; full forms carry source first
// - Opcodes 12-17 hex are add with carry
// - Opcodes 02-07 hex are plain add
// - Carry add sums dst, src, carry
// - Plain add sums dst and src only
// - Zero flag set when result is zero
// - Sign flag copies result bit 7
// - Overflow on same-sign operands, flipped result
// - Decimal flag cleared; half carry from bit 3
// - Each instruction completes in ten cycles
//
// The implementer's own choices: the address-and-strobe port and the register addresses.
module bsa_byte_sum_alu import bsa_pkg::*; (
	input wire logic clk, // Core clock
	input wire logic rstn, // Synchronous reset, active low
	input wire logic start, // Instruction present, one-cycle pulse
	input wire bsa_instr_type instr, // Instruction bytes in machine order
	input wire logic carry_in, // Current carry flag
	input wire logic [7:0] reg_pointer, // Working register pointer
	output logic busy, // Instruction in progress
	output logic done, // Instruction complete, one-cycle pulse
	output logic reject, // Start with an opcode outside this unit
	output logic rd_en, // Register file read strobe
	output logic [7:0] rd_addr, // Register file read address
	input wire logic [7:0] rd_data, // Read data, one cycle after strobe
	output logic wr_en, // Register file write strobe
	output logic [7:0] wr_addr, // Register file write address
	output logic [7:0] wr_data, // Sum written back
	output logic flags_we, // Flag update strobe
	output bsa_flags_type flags_out, // Flags after the addition
	output logic [7:0] pair_addr // Register pair named by the first operand
);

	// ==========================================================
	// Decoding helpers

	// Working register address from a nibble
	function automatic logic [7:0] work_addr(input logic [7:0] rp, input logic [3:0] nib);
		work_addr = {rp[7:4], nib};
	endfunction : work_addr

	// Full register operand, with the working short form
	function automatic logic [7:0] resolve_reg(input logic [7:0] rp, input logic [7:0] b);
		if (b[7:4] == WORK_NIBBLE) begin
			resolve_reg = work_addr(rp, b[3:0]);
		end else begin
			resolve_reg = b;
		end
	endfunction : resolve_reg

	// Register pair operand, even address of the pair
	function automatic logic [7:0] resolve_pair(input logic [7:0] rp, input logic [7:0] b);
		if (b[7:4] == WORK_NIBBLE) begin
			resolve_pair = {rp[7:4], b[3:1], 1'b0};
		end else begin
			resolve_pair = {b[7:1], 1'b0};
		end
	endfunction : resolve_pair

	// Opcode belongs to one of the two add groups
	function automatic logic op_known(input logic [7:0] op);
		op_known = ((op[7:4] == OP_HI_ADD) || (op[7:4] == OP_HI_ADC))
			&& (op[3:0] >= MODE_WW) && (op[3:0] <= MODE_IL);
	endfunction : op_known

	// ==========================================================
	// State
	bsa_state_type state_reg, state_next;
	logic [3:0] cnt_reg, cnt_next;
	logic adc_reg, adc_next;
	logic cin_reg, cin_next;
	logic src_ind_reg, src_ind_next;
	logic dst_ind_reg, dst_ind_next;
	logic src_imm_reg, src_imm_next;
	logic [7:0] src_addr_reg, src_addr_next;
	logic [7:0] dst_addr_reg, dst_addr_next;
	logic [7:0] src_val_reg, src_val_next;
	logic [7:0] dst_val_reg, dst_val_next;
	logic rd_en_reg, rd_en_next;
	logic [7:0] rd_addr_reg, rd_addr_next;
	logic wr_en_reg, wr_en_next;
	logic [7:0] wr_addr_reg, wr_addr_next;
	logic [7:0] wr_data_reg, wr_data_next;
	bsa_flags_type flags_reg, flags_next;
	logic [7:0] pair_reg, pair_next;
	logic accept;
	logic [8:0] sum9;
	logic [4:0] low5;

	assign accept = (state_reg == ST_IDLE) && start && op_known(instr.operation_code_byte);

	// Sum of the destination as it arrives from the register file and the held source
	always_comb begin
		sum9 = {1'b0, rd_data} + {1'b0, src_val_reg} + {8'h00, adc_reg & cin_reg};
		low5 = {1'b0, rd_data[3:0]} + {1'b0, src_val_reg[3:0]}
			+ {4'h0, adc_reg & cin_reg};
	end

	// Sequencer: decode, pointer fetch, operand fetch, compute, write, pad
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		adc_next = adc_reg;
		cin_next = cin_reg;
		src_ind_next = src_ind_reg;
		dst_ind_next = dst_ind_reg;
		src_imm_next = src_imm_reg;
		src_addr_next = src_addr_reg;
		dst_addr_next = dst_addr_reg;
		src_val_next = src_val_reg;
		dst_val_next = dst_val_reg;
		rd_en_next = 1'b0;
		rd_addr_next = rd_addr_reg;
		wr_en_next = 1'b0;
		wr_addr_next = wr_addr_reg;
		wr_data_next = wr_data_reg;
		flags_next = flags_reg;
		pair_next = pair_reg;
		if (state_reg != ST_IDLE) begin
			cnt_next = cnt_reg + ONE_CYCLE;
		end
		unique case (state_reg)
			ST_IDLE: begin
				cnt_next = BYTE_ZERO[3:0];
				if (accept) begin
					adc_next = (instr.operation_code_byte[7:4] == OP_HI_ADC);
					cin_next = carry_in;
					src_ind_next = 1'b0;
					dst_ind_next = 1'b0;
					src_imm_next = 1'b0;
					pair_next = resolve_pair(reg_pointer, instr.first_operand);
					cnt_next = ONE_CYCLE;
					state_next = ST_PTR;
					unique case (instr.operation_code_byte[3:0])
						MODE_WW: begin
							dst_addr_next = work_addr(reg_pointer, instr.first_operand[7:4]);
							src_addr_next = work_addr(reg_pointer, instr.first_operand[3:0]);
						end
						MODE_WI: begin
							dst_addr_next = work_addr(reg_pointer, instr.first_operand[7:4]);
							src_addr_next = work_addr(reg_pointer, instr.first_operand[3:0]);
							src_ind_next = 1'b1;
						end
						MODE_RR: begin
							src_addr_next = resolve_reg(reg_pointer, instr.first_operand);
							dst_addr_next = resolve_reg(reg_pointer, instr.second_operand);
						end
						MODE_RI: begin
							src_addr_next = resolve_reg(reg_pointer, instr.first_operand);
							dst_addr_next = resolve_reg(reg_pointer, instr.second_operand);
							src_ind_next = 1'b1;
						end
						MODE_RL: begin
							dst_addr_next = resolve_reg(reg_pointer, instr.first_operand);
							src_val_next = instr.second_operand;
							src_imm_next = 1'b1;
						end
						default: begin // Only MODE_IL remains once op_known holds
							dst_addr_next = resolve_reg(reg_pointer, instr.first_operand);
							src_val_next = instr.second_operand;
							src_imm_next = 1'b1;
							dst_ind_next = 1'b1;
						end
					endcase
					// Pointer register read for indirect forms
					rd_en_next = src_ind_next || dst_ind_next;
					rd_addr_next = src_ind_next ? src_addr_next : dst_addr_next;
				end
			end
			ST_PTR: begin
				state_next = ST_PTRL;
			end
			ST_PTRL: begin
				// Pointer contents become the operand address
				if (src_ind_reg) begin
					src_addr_next = rd_data;
				end
				if (dst_ind_reg) begin
					dst_addr_next = rd_data;
				end
				rd_en_next = !src_imm_reg;
				rd_addr_next = src_addr_next;
				state_next = ST_SRC;
			end
			ST_SRC: begin
				rd_en_next = 1'b1;
				rd_addr_next = dst_addr_reg;
				state_next = ST_DST;
			end
			ST_DST: begin
				if (!src_imm_reg) begin
					src_val_next = rd_data;
				end
				state_next = ST_CALC;
			end
			ST_CALC: begin
				// Source is only read, destination takes the sum
				dst_val_next = rd_data;
				wr_en_next = 1'b1;
				wr_addr_next = dst_addr_reg;
				wr_data_next = sum9[7:0];
				flags_next.c = sum9[8];
				flags_next.z = (sum9[7:0] == BYTE_ZERO);
				flags_next.s = sum9[7];
				flags_next.v = (rd_data[7] == src_val_reg[7])
					&& (sum9[7] != src_val_reg[7]);
				flags_next.d = 1'b0;
				flags_next.h = low5[4];
				state_next = ST_WR;
			end
			ST_WR: begin
				state_next = ST_HOLD;
			end
			ST_HOLD: begin
				// Pad to the fixed instruction length
				if (cnt_reg == LAST_CYCLE) begin
					state_next = ST_IDLE;
				end
			end
		endcase
	end

	// State registers
	always_ff @(posedge clk) begin
		if (!rstn) begin
			state_reg <= ST_IDLE;
			cnt_reg <= BYTE_ZERO[3:0];
			adc_reg <= 1'b0;
			cin_reg <= 1'b0;
			src_ind_reg <= 1'b0;
			dst_ind_reg <= 1'b0;
			src_imm_reg <= 1'b0;
			src_addr_reg <= BYTE_ZERO;
			dst_addr_reg <= BYTE_ZERO;
			src_val_reg <= BYTE_ZERO;
			dst_val_reg <= BYTE_ZERO;
			rd_en_reg <= 1'b0;
			rd_addr_reg <= BYTE_ZERO;
			wr_en_reg <= 1'b0;
			wr_addr_reg <= BYTE_ZERO;
			wr_data_reg <= BYTE_ZERO;
			flags_reg <= '0;
			pair_reg <= BYTE_ZERO;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			adc_reg <= adc_next;
			cin_reg <= cin_next;
			src_ind_reg <= src_ind_next;
			dst_ind_reg <= dst_ind_next;
			src_imm_reg <= src_imm_next;
			src_addr_reg <= src_addr_next;
			dst_addr_reg <= dst_addr_next;
			src_val_reg <= src_val_next;
			dst_val_reg <= dst_val_next;
			rd_en_reg <= rd_en_next;
			rd_addr_reg <= rd_addr_next;
			wr_en_reg <= wr_en_next;
			wr_addr_reg <= wr_addr_next;
			wr_data_reg <= wr_data_next;
			flags_reg <= flags_next;
			pair_reg <= pair_next;
		end
	end

	// Outputs
	assign busy = (state_reg != ST_IDLE);
	assign done = (state_reg == ST_HOLD) && (cnt_reg == LAST_CYCLE);
	assign reject = (state_reg == ST_IDLE) && start && !op_known(instr.operation_code_byte);
	assign rd_en = rd_en_reg;
	assign rd_addr = rd_addr_reg;
	assign wr_en = wr_en_reg;
	assign wr_addr = wr_addr_reg;
	assign wr_data = wr_data_reg;
	assign flags_we = wr_en_reg;
	assign flags_out = flags_reg;
	assign pair_addr = pair_reg;

	// ==========================================================
	// Checks
	a_done_ten_cycles: assert property (@(posedge clk) disable iff (!rstn)
		accept |=> !done [*8] ##1 done)
		else $error("done not nine cycles after accepted start");

	a_zero_flag: assert property (@(posedge clk) disable iff (!rstn)
		flags_we |-> (flags_out.z == (wr_data == BYTE_ZERO)))
		else $error("zero flag disagrees with result");

	a_sign_flag: assert property (@(posedge clk) disable iff (!rstn)
		flags_we |-> (flags_out.s == wr_data[7]))
		else $error("sign flag disagrees with result bit 7");

	a_decimal_clear: assert property (@(posedge clk) disable iff (!rstn)
		flags_we |-> !flags_out.d)
		else $error("decimal flag not cleared");

	a_carry_sum: assert property (@(posedge clk) disable iff (!rstn)
		(flags_we && adc_reg) |->
		({flags_out.c, wr_data} == ({1'b0, dst_val_reg} + {1'b0, src_val_reg}
		+ {8'h00, cin_reg})))
		else $error("carry add result or carry wrong");

	a_plain_sum: assert property (@(posedge clk) disable iff (!rstn)
		(flags_we && !adc_reg) |->
		({flags_out.c, wr_data} == ({1'b0, dst_val_reg} + {1'b0, src_val_reg})))
		else $error("plain add result or carry wrong");

	a_overflow_flag: assert property (@(posedge clk) disable iff (!rstn)
		flags_we |-> (flags_out.v == ((dst_val_reg[7] == src_val_reg[7])
		&& (wr_data[7] != dst_val_reg[7]))))
		else $error("overflow flag wrong");

	a_half_carry: assert property (@(posedge clk) disable iff (!rstn)
		flags_we |-> (flags_out.h == (dst_val_reg[4] ^ src_val_reg[4] ^ wr_data[4])))
		else $error("half carry flag wrong");

	a_work_dst: assert property (@(posedge clk) disable iff (!rstn)
		(accept && (instr.operation_code_byte[3:0] == MODE_RR)
		&& (instr.second_operand[7:4] == WORK_NIBBLE)) |->
		##6 (wr_en && (wr_addr == {$past(reg_pointer[7:4], 6), $past(instr.second_operand[3:0], 6)})))
		else $error("working destination address wrong");

	a_pointer_read: assert property (@(posedge clk) disable iff (!rstn)
		(accept && (instr.operation_code_byte[3:0] == MODE_WI)) |->
		##1 rd_en ##2 (rd_en && (rd_addr == $past(rd_data))))
		else $error("indirect source not read through pointer");

endmodule : bsa_byte_sum_alu

// >>> test/bsa_regfile_model.sv
// Register file model that stands behind the add unit.
// Assumes one core clock; read data is valid only in the cycle after a read strobe.
module bsa_regfile_model (
	input wire logic clk, // Core clock
	input wire logic rd_en, // Read strobe
	input wire logic [7:0] rd_addr, // Read address
	output logic [7:0] rd_data, // Read data
	input wire logic wr_en, // Write strobe
	input wire logic [7:0] wr_addr, // Write address
	input wire logic [7:0] wr_data // Write data
);
	timeunit 1ns;
	timeprecision 1ps;

	// ==========================================================
	// Storage
	logic [7:0] mem [256];
	logic [7:0] last_q = 8'h00;
	logic valid_q = 1'b0;

	// Answer one cycle after the strobe and take writes
	always @(posedge clk) begin
		valid_q <= rd_en;
		if (rd_en) last_q <= mem[rd_addr];
		if (wr_en) mem[wr_addr] <= wr_data;
	end

	// Outside the answer cycle show the inverse, so stale data never looks valid
	assign rd_data = valid_q ? last_q : ~last_q;
endmodule : bsa_regfile_model

// >>> test/bsa_byte_sum_alu_tb.sv
// Self-checking bench of the add unit with a register file model.
// Assumes a 40 MHz core clock and working registers at 20 hex.
module bsa_byte_sum_alu_tb import bsa_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;

	// ==========================================================
	// Signals
	logic clk, rstn, start, carry_in, busy, done, reject, rd_en, wr_en, flags_we;
	logic [7:0] reg_pointer, rd_addr, rd_data, wr_addr, wr_data, pair_addr;
	bsa_instr_type instr;
	bsa_flags_type flags_out;
	int fail_count = 0;
	int checked = 0;

	// Core clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// Unit under test and its register file
	bsa_byte_sum_alu dut_u (.clk(clk), .rstn(rstn), .start(start), .instr(instr),
		.carry_in(carry_in), .reg_pointer(reg_pointer), .busy(busy), .done(done),
		.reject(reject), .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data),
		.wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .flags_we(flags_we),
		.flags_out(flags_out), .pair_addr(pair_addr));
	bsa_regfile_model rf_u (.clk(clk), .rd_en(rd_en), .rd_addr(rd_addr),
		.rd_data(rd_data), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data));

	// ==========================================================
	// Shared tasks
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string what);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask : cmp

	task automatic results();
		if (fail_count == 0 && checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : results

	// One instruction; operands change while busy, poke repeats start then
	task automatic run(input logic [7:0] op, b1, b2, input logic ci, poke, output int k);
		int w;
		@(posedge clk);
		start <= 1'b1;
		instr <= {op, b1, b2};
		carry_in <= ci;
		@(posedge clk);
		start <= poke;
		instr <= 24'h02e1e2;
		carry_in <= ~ci;
		@(negedge clk);
		@(posedge clk);
		start <= 1'b0;
		k = 2;
		w = 0;
		@(negedge clk);
		while (done !== 1'b1 && k < 20) begin
			if (flags_we === 1'b1) w = k;
			@(negedge clk);
			k++;
		end
		if (k == 20) begin
			cmp(8'h00, 8'h01, "timeout");
			results();
		end
		cmp(8'(w), 8'h06, "flag strobe cycle");
	endtask : run

	// ==========================================================
	// Scenarios
	// Every opcode of both groups with flag corner values
	task automatic t_ops();
		logic [7:0] dv [12] = '{8'h16, 8'hff, 8'h7f, 8'h80, 8'h2e, 8'h82,
			8'h16, 8'h00, 8'h2e, 8'h82, 8'h2a, 8'h8f};
		logic [7:0] sv [12] = '{8'h20, 8'h01, 8'h01, 8'h80, 8'h1b, 8'h01,
			8'h20, 8'h00, 8'h1b, 8'h80, 8'h03, 8'h70};
		logic [7:0] b1t [6] = '{8'h3b, 8'h3a, 8'h12, 8'he3, 8'h6c, 8'hd4};
		logic [7:0] dat [6] = '{8'h23, 8'h23, 8'h24, 8'h4b, 8'h6c, 8'h5f};
		logic [7:0] b2t [6] = '{8'h23, 8'h23, 8'he4, 8'h4b, 8'h00, 8'h00};
		logic [7:0] sat [6] = '{8'h2b, 8'h50, 8'h12, 8'h50, 8'h00, 8'h00};
		logic [7:0] pat [6] = '{8'h00, 8'h2a, 8'h00, 8'h23, 8'h00, 8'hd4};
		logic [7:0] pvt [6] = '{8'h00, 8'h50, 8'h00, 8'h50, 8'h00, 8'h5f};
		logic [7:0] prt [4] = '{8'h12, 8'h22, 8'h6c, 8'hd4};
		logic [5:0] cv = 6'b101101;
		logic [8:0] sum9;
		logic ci, ce, v, h;
		int j, k;
		for (int i = 0; i < 12; i++) begin
			j = i % 6;
			ci = (i < 6) | cv[j];
			ce = ci & (i > 5);
			rf_u.mem[pat[j]] = pvt[j];
			rf_u.mem[dat[j]] = dv[i];
			if (j < 4) rf_u.mem[sat[j]] = sv[i];
			sum9 = {1'b0, dv[i]} + {1'b0, sv[i]} + {8'h00, ce};
			v = (dv[i][7] == sv[i][7]) && (sum9[7] != dv[i][7]);
			h = ({1'b0, dv[i][3:0]} + {1'b0, sv[i][3:0]} + {4'h0, ce}) > 5'h0f;
			run({3'h0, i > 5, 4'(j + 2)}, b1t[j], j > 3 ? sv[i] : b2t[j], ci, j == 4, k);
			cmp(8'(k), 8'h09, "done cycle");
			cmp(wr_addr, dat[j], "dest addr");
			cmp(rf_u.mem[dat[j]], sum9[7:0], "sum");
			cmp({2'b00, flags_out}, {2'b00, sum9[8], sum9[7:0] == 8'h00, sum9[7], v, 1'b0, h},
				"flags");
			if (j < 4) cmp(rf_u.mem[sat[j]], sv[i], "source kept");
			if (j > 1) cmp(pair_addr, prt[j - 2], "pair");
		end
	endtask : t_ops

	// Opcodes outside both groups are refused and leave the unit idle
	task automatic t_reject();
		logic [7:0] bad [6] = '{8'h00, 8'h01, 8'h08, 8'h10, 8'h18, 8'h52};
		foreach (bad[n]) begin
			@(posedge clk);
			start <= 1'b1;
			instr <= {bad[n], 16'he3e4};
			@(negedge clk);
			cmp({7'h00, reject}, 8'h01, "reject");
			@(posedge clk);
			start <= 1'b0;
			@(negedge clk);
			cmp({7'h00, busy}, 8'h00, "busy after reject");
		end
	endtask : t_reject

	// ==========================================================
	// Main sequence
	initial begin
		rstn = 1'b0;
		start = 1'b0;
		instr = '0;
		carry_in = 1'b0;
		reg_pointer = 8'h20;
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		@(negedge clk);
		cmp({6'h00, busy, done}, 8'h00, "idle after reset");
		t_ops();
		t_reject();
		results();
	end
endmodule : bsa_byte_sum_alu_tb
